//--- rtl/tbh_params.svh
// Constants for the trap, branch hint and special register decoder
`ifndef TBH_PARAMS_SVH
`define TBH_PARAMS_SVH

// ----------------------------------------
// Special register numbers
// ----------------------------------------
`define TBH_SPR_FXE 10'h001
`define TBH_SPR_LINK 10'h008
`define TBH_SPR_COUNT 10'h009
`define TBH_SPR_FSRC 10'h012
`define TBH_SPR_FADDR 10'h013
`define TBH_SPR_DOWN 10'h016
`define TBH_SPR_SVPC 10'h01a
`define TBH_SPR_SVST 10'h01b
`define TBH_SPR_SCR_BASE 10'h110

// ----------------------------------------
// Trap mask bit positions (vector index)
// ----------------------------------------
`define TBH_TM_LT 4
`define TBH_TM_GT 3
`define TBH_TM_SAME 2
`define TBH_TM_LTU 1
`define TBH_TM_GTU 0
`define TBH_TM_ALL 5'h1f

// ----------------------------------------
// Branch options, condition bit select and reset values
// ----------------------------------------
`define TBH_HINT_BIT 0
`define TBH_SPR_RST 32'h0000_0000
`define TBH_FLAG_TOP 5'h1f

`endif

//--- rtl/tbh_pkg.sv
// Types shared by the trap, branch hint and special register decoder
package tbh_pkg;

   typedef enum logic [1:0] {
      TBH_IDLE = 2'b01,
      TBH_RAISE = 2'b10
   } tbh_trap_state_type;

   typedef enum logic [3:0] {
      TBH_R_FXE = 4'h0,
      TBH_R_LINK = 4'h1,
      TBH_R_COUNT = 4'h2,
      TBH_R_FSRC = 4'h3,
      TBH_R_FADDR = 4'h4,
      TBH_R_DOWN = 4'h5,
      TBH_R_SVPC = 4'h6,
      TBH_R_SVST = 4'h7,
      TBH_R_SCR0 = 4'h8,
      TBH_R_SCR1 = 4'h9,
      TBH_R_SCR2 = 4'ha,
      TBH_R_SCR3 = 4'hb
   } tbh_spr_idx_type;

   typedef logic [4:0] tbh_cond_type;

endpackage

//--- rtl/tbh_compare.sv
// Five-way signed and unsigned comparator for trap evaluation
`timescale 1ns/1ps
`include "tbh_params.svh"

module tbh_compare
   import tbh_pkg::*;
#(
   parameter int XLEN = 32
) (
   input wire logic [XLEN-1:0] op_a,
   input wire logic [XLEN-1:0] op_b,
   output tbh_cond_type cond
);

   always_comb begin
      cond = '0;
      cond[`TBH_TM_LT] = $signed(op_a) < $signed(op_b);
      cond[`TBH_TM_GT] = $signed(op_a) > $signed(op_b);
      cond[`TBH_TM_SAME] = op_a == op_b;
      cond[`TBH_TM_LTU] = op_a < op_b;
      cond[`TBH_TM_GTU] = op_a > op_b;
   end

endmodule // tbh_compare

//--- rtl/tbh_decode.sv
// Trap evaluation, static branch prediction and special register decode
`timescale 1ns/1ps
`include "tbh_params.svh"

module tbh_decode
   import tbh_pkg::*;
#(
   parameter int XLEN = 32,
   parameter int IMM_W = 16,
   parameter int DISP_W = 14
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic trap_valid,
   input wire logic trap_imm_form,
   input wire logic [4:0] trap_condition_mask,
   input wire logic [XLEN-1:0] first_source_gpr,
   input wire logic [XLEN-1:0] second_source_gpr,
   input wire logic [IMM_W-1:0] signed_immediate,
   input wire logic trap_ack,
   output logic trap_req_q,
   output tbh_cond_type trap_cond_q,
   input wire logic br_valid,
   input wire logic br_reg_target,
   input wire logic [4:0] branch_options_field,
   input wire logic [DISP_W-1:0] br_disp,
   output logic pred_valid_q,
   output logic pred_taken_q,
   input wire logic flag_valid,
   input wire logic [4:0] condition_flag_select,
   input wire logic [31:0] condition_register,
   output logic flag_value_q,
   output logic [2:0] flag_field_q,
   output logic [1:0] flag_pos_q,
   input wire logic spr_valid,
   input wire logic spr_write,
   input wire logic [9:0] spr_num,
   input wire logic [XLEN-1:0] spr_wdata,
   output logic [XLEN-1:0] spr_rdata_q,
   output logic spr_hit_q,
   output logic spr_bad_q
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (IMM_W < 2 || IMM_W > XLEN || DISP_W < 2 || DISP_W > XLEN) begin : g_bad_width
      $error("tbh_decode: immediate or displacement width out of range");
   end

   localparam int NSPR = 12;

   // ----------------------------------------
   // Trap evaluation
   // ----------------------------------------
   tbh_trap_state_type trap_st_q;
   logic [XLEN-1:0] trap_b;
   tbh_cond_type trap_cond;
   tbh_cond_type trap_masked;
   logic trap_take;

   // Immediate form compares against the sign-extended field
   assign trap_b = trap_imm_form ?
      {{(XLEN-IMM_W){signed_immediate[IMM_W-1]}}, signed_immediate} :
      second_source_gpr;

   tbh_compare #(
      .XLEN(XLEN)
   ) u_cmp (
      .op_a(first_source_gpr),
      .op_b(trap_b),
      .cond(trap_cond)
   );

   // Mask index 4 holds field bit 0, so codes read as printed
   assign trap_masked = trap_cond & trap_condition_mask;
   // A full mask always hits one of lt, gt or equal
   assign trap_take = trap_valid && (trap_st_q == TBH_IDLE) && (|trap_masked);

   // New traps are ignored while one waits for its acknowledge
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         trap_st_q <= TBH_IDLE;
      end else begin
         unique case (trap_st_q)
            TBH_IDLE: begin
               if (trap_take) begin
                  trap_st_q <= TBH_RAISE;
               end
            end
            TBH_RAISE: begin
               if (trap_ack) begin
                  trap_st_q <= TBH_IDLE;
               end
            end
            default: begin
               trap_st_q <= TBH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         trap_req_q <= 1'b0;
      end else if (trap_take) begin
         trap_req_q <= 1'b1;
      end else if (trap_ack) begin
         trap_req_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         trap_cond_q <= '0;
      end else if (trap_valid && trap_st_q == TBH_IDLE) begin
         trap_cond_q <= trap_masked;
      end
   end

   // ----------------------------------------
   // Static branch prediction
   // ----------------------------------------
   logic br_hint;
   logic br_pred;

   // Only the hint bit matters here, never the condition bits
   assign br_hint = branch_options_field[`TBH_HINT_BIT];
   // Register targets are unknown at decode, so follow the hint bit alone
   assign br_pred = br_reg_target ? br_hint :
      (br_disp[DISP_W-1] ^ br_hint);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pred_valid_q <= 1'b0;
         pred_taken_q <= 1'b0;
      end else begin
         pred_valid_q <= br_valid;
         if (br_valid) begin
            pred_taken_q <= br_pred;
         end
      end
   end

   // ----------------------------------------
   // Condition bit select
   // ----------------------------------------
   // Bit 0 of the condition register is its most significant bit
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flag_value_q <= 1'b0;
         flag_field_q <= '0;
         flag_pos_q <= '0;
      end else if (flag_valid) begin
         flag_field_q <= condition_flag_select[4:2];
         flag_pos_q <= condition_flag_select[1:0];
         flag_value_q <= condition_register[`TBH_FLAG_TOP - condition_flag_select];
      end
   end

   // ----------------------------------------
   // Special register decode and storage
   // ----------------------------------------
   logic [XLEN-1:0] spr_mem_q [NSPR];
   tbh_spr_idx_type spr_idx;
   logic spr_hit;

   always_comb begin
      spr_idx = TBH_R_FXE;
      spr_hit = 1'b1;
      unique case (spr_num)
         `TBH_SPR_FXE: spr_idx = TBH_R_FXE;
         `TBH_SPR_LINK: spr_idx = TBH_R_LINK;
         `TBH_SPR_COUNT: spr_idx = TBH_R_COUNT;
         `TBH_SPR_FSRC: spr_idx = TBH_R_FSRC;
         `TBH_SPR_FADDR: spr_idx = TBH_R_FADDR;
         `TBH_SPR_DOWN: spr_idx = TBH_R_DOWN;
         `TBH_SPR_SVPC: spr_idx = TBH_R_SVPC;
         `TBH_SPR_SVST: spr_idx = TBH_R_SVST;
         `TBH_SPR_SCR_BASE: spr_idx = TBH_R_SCR0;
         `TBH_SPR_SCR_BASE + 10'h001: spr_idx = TBH_R_SCR1;
         `TBH_SPR_SCR_BASE + 10'h002: spr_idx = TBH_R_SCR2;
         `TBH_SPR_SCR_BASE + 10'h003: spr_idx = TBH_R_SCR3;
         default: spr_hit = 1'b0;
      endcase
   end

   // Unknown numbers neither write nor disturb any register
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NSPR; i++) begin
            spr_mem_q[i] <= `TBH_SPR_RST;
         end
      end else if (spr_valid && spr_write && spr_hit) begin
         spr_mem_q[spr_idx] <= spr_wdata;
      end
   end

   // Read data is the stored word before any same-cycle write
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         spr_rdata_q <= '0;
         spr_hit_q <= 1'b0;
         spr_bad_q <= 1'b0;
      end else begin
         spr_hit_q <= spr_valid && spr_hit;
         spr_bad_q <= spr_valid && !spr_hit;
         if (spr_valid && !spr_write && spr_hit) begin
            spr_rdata_q <= spr_mem_q[spr_idx];
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_trap_idle;
      trap_valid && trap_st_q == TBH_IDLE;
   endsequence

   sequence s_spr_wr;
      spr_valid && spr_write && spr_hit;
   endsequence

   sequence s_spr_rd_same;
      spr_valid && !spr_write && spr_num == $past(spr_num);
   endsequence

   property p_trap_imm;
      @(posedge clock) disable iff (sys_rst)
      trap_valid && trap_imm_form |->
         $signed(trap_b) == $signed(signed_immediate);
   endproperty
   a_trap_imm: assert property (p_trap_imm)
      else $error("immediate trap operand not sign extended");

   property p_trap_slt;
      @(posedge clock) disable iff (sys_rst)
      s_trap_idle ##0 (trap_condition_mask[4] &&
         $signed(first_source_gpr) < $signed(trap_b)) |=> trap_req_q && trap_cond_q[4];
   endproperty
   a_trap_slt: assert property (p_trap_slt)
      else $error("signed less-than trap missed");

   property p_trap_ugt;
      @(posedge clock) disable iff (sys_rst)
      s_trap_idle ##0 (trap_condition_mask[0] && first_source_gpr > trap_b)
         |=> trap_req_q && trap_cond_q[0];
   endproperty
   a_trap_ugt: assert property (p_trap_ugt)
      else $error("unsigned greater-than trap missed");

   property p_trap_same;
      @(posedge clock) disable iff (sys_rst)
      s_trap_idle ##0 (trap_condition_mask[2] && first_source_gpr == trap_b)
         |=> trap_req_q && trap_cond_q[2];
   endproperty
   a_trap_same: assert property (p_trap_same)
      else $error("equality trap missed");

   property p_trap_refuse;
      @(posedge clock) disable iff (sys_rst)
      trap_st_q == TBH_RAISE |=> $stable(trap_cond_q);
   endproperty
   a_trap_refuse: assert property (p_trap_refuse)
      else $error("pending trap overwritten by a refused one");

   property p_trap_none;
      @(posedge clock) disable iff (sys_rst)
      s_trap_idle ##0 ((trap_cond & trap_condition_mask) == 5'h00)
         |=> !trap_req_q && trap_cond_q == 5'h00;
   endproperty
   a_trap_none: assert property (p_trap_none)
      else $error("trap raised with no masked condition");

   property p_trap_all;
      @(posedge clock) disable iff (sys_rst)
      s_trap_idle ##0 (!trap_imm_form && trap_condition_mask == `TBH_TM_ALL)
         |=> trap_req_q;
   endproperty
   a_trap_all: assert property (p_trap_all)
      else $error("full-mask trap not unconditional");

   property p_trap_hold;
      @(posedge clock) disable iff (sys_rst)
      trap_req_q && !trap_ack |=> trap_req_q;
   endproperty
   a_trap_hold: assert property (p_trap_hold)
      else $error("trap request dropped before acknowledge");

   property p_pred_disp;
      @(posedge clock) disable iff (sys_rst)
      br_valid && !br_reg_target |=>
         pred_valid_q && pred_taken_q == ($past(br_disp[DISP_W-1]) != $past(br_hint));
   endproperty
   a_pred_disp: assert property (p_pred_disp)
      else $error("displacement branch prediction wrong");

   property p_pred_reg;
      @(posedge clock) disable iff (sys_rst)
      br_valid && br_reg_target |=>
         pred_taken_q == $past(branch_options_field[0]);
   endproperty
   a_pred_reg: assert property (p_pred_reg)
      else $error("register-target branch prediction wrong");

   property p_flag_sel;
      @(posedge clock) disable iff (sys_rst)
      flag_valid |=> flag_value_q ==
         $past(condition_register[31 - condition_flag_select]) &&
         {flag_field_q, flag_pos_q} == $past(condition_flag_select);
   endproperty
   a_flag_sel: assert property (p_flag_sel)
      else $error("condition bit select wrong");

   property p_spr_map;
      @(posedge clock) disable iff (sys_rst)
      spr_valid && (spr_num inside {10'h001, 10'h008, 10'h009, 10'h012, 10'h013,
         10'h016, 10'h01a, 10'h01b, [10'h110:10'h113]}) |=> spr_hit_q && !spr_bad_q;
   endproperty
   a_spr_map: assert property (p_spr_map)
      else $error("special register number not decoded");

   property p_spr_rt;
      @(posedge clock) disable iff (sys_rst)
      s_spr_wr ##1 s_spr_rd_same |=> spr_rdata_q == $past(spr_wdata, 2);
   endproperty
   a_spr_rt: assert property (p_spr_rt)
      else $error("special register write not read back");

endmodule // tbh_decode

//--- tb/tbh_exc_model.sv
// Exception unit stand-in that acknowledges trap requests
`timescale 1ns/1ps
module tbh_exc_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic trap_req_q,
   input wire logic slow,
   output logic trap_ack
);
   logic [2:0] wait_q;
   // Slow mode keeps a trap pending long enough to see refusals
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wait_q <= 3'h0;
         trap_ack <= 1'b0;
      end else if (trap_req_q && !trap_ack) begin
         if (wait_q >= (slow ? 3'h4 : 3'h0)) begin
            trap_ack <= 1'b1;
            wait_q <= 3'h0;
         end else begin
            wait_q <= wait_q + 3'h1;
         end
      end else begin
         trap_ack <= 1'b0;
      end
   end
endmodule // tbh_exc_model

//--- tb/tb.sv
// Self-checking bench for the trap, branch hint and special register decoder
`timescale 1ns/1ps
module tb
   import tbh_pkg::*;
;
   logic clock, sys_rst, slow, trap_valid, trap_imm_form, trap_ack, trap_req_q;
   logic [4:0] trap_condition_mask;
   logic [31:0] first_source_gpr, second_source_gpr;
   logic [15:0] signed_immediate;
   tbh_cond_type trap_cond_q;
   logic br_valid, br_reg_target, pred_valid_q, pred_taken_q;
   logic [4:0] branch_options_field;
   logic [13:0] br_disp;
   logic flag_valid, flag_value_q;
   logic [4:0] condition_flag_select;
   logic [31:0] condition_register;
   logic [2:0] flag_field_q;
   logic [1:0] flag_pos_q;
   logic spr_valid, spr_write, spr_hit_q, spr_bad_q;
   logic [9:0] spr_num;
   logic [31:0] spr_wdata, spr_rdata_q;
   int err_total = 0;
   int checks_done = 0;
   int spr_list [12] = '{1, 8, 9, 18, 19, 22, 26, 27, 272, 273, 274, 275};
   int bad_list [7] = '{0, 2, 268, 271, 276, 287, 1023};

   tbh_decode u_tbh_decode (.clock, .sys_rst, .trap_valid, .trap_imm_form,
      .trap_condition_mask, .first_source_gpr, .second_source_gpr, .signed_immediate,
      .trap_ack, .trap_req_q, .trap_cond_q, .br_valid, .br_reg_target,
      .branch_options_field, .br_disp, .pred_valid_q, .pred_taken_q, .flag_valid,
      .condition_flag_select, .condition_register, .flag_value_q, .flag_field_q,
      .flag_pos_q, .spr_valid, .spr_write, .spr_num, .spr_wdata, .spr_rdata_q,
      .spr_hit_q, .spr_bad_q);
   tbh_exc_model u_tbh_exc_model (.clock, .sys_rst, .trap_req_q, .slow, .trap_ack);

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ---------------------------------------------
   // Compare and verdict
   // ---------------------------------------------
   task automatic chk_bit(string what, logic exp, logic got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_vec(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Trap scenarios
   // ---------------------------------------------
   function automatic logic [4:0] conds(logic [31:0] a, logic [31:0] b);
      return {$signed(a) < $signed(b), $signed(a) > $signed(b), a == b, a < b, a > b};
   endfunction

   task automatic wait_idle();
      int n;
      n = 0;
      while (trap_req_q !== 1'b0 && n < 20) begin
         @(negedge clock);
         n++;
      end
      chk_bit("trap released", 1'b0, trap_req_q);
   endtask

   // Immediate form puts a copy of a on the register operand to expose a wrong pick
   task automatic run_trap(logic form, logic [4:0] mask, logic [31:0] a, logic [31:0] b);
      logic [4:0] exp;
      exp = mask & conds(a, form ? {{16{b[15]}}, b[15:0]} : b);
      @(posedge clock);
      trap_valid <= 1'b1;
      trap_imm_form <= form;
      trap_condition_mask <= mask;
      first_source_gpr <= a;
      second_source_gpr <= form ? a : b;
      signed_immediate <= b[15:0];
      @(posedge clock);
      trap_valid <= 1'b0;
      @(negedge clock);
      chk_vec("trap_cond_q", 32'(exp), 32'(trap_cond_q));
      chk_bit("trap_req_q", |exp, trap_req_q);
      wait_idle();
   endtask

   task automatic trap_refused();
      @(posedge clock);
      slow <= 1'b1;
      trap_valid <= 1'b1;
      trap_imm_form <= 1'b0;
      trap_condition_mask <= 5'h1f;
      first_source_gpr <= 32'h9;
      second_source_gpr <= 32'h9;
      @(posedge clock);
      trap_condition_mask <= 5'h10;
      first_source_gpr <= 32'h0;
      @(posedge clock);
      trap_valid <= 1'b0;
      @(negedge clock);
      chk_vec("held cond", 32'h4, 32'(trap_cond_q));
      chk_bit("held req", 1'b1, trap_req_q);
      wait_idle();
      slow <= 1'b0;
   endtask

   // ---------------------------------------------
   // Branch, flag and special register scenarios
   // ---------------------------------------------
   task automatic branch_cases();
      logic exp;
      for (int i = 0; i < 8; i++) begin
         exp = i[2] ? i[0] : (i[1] ^ i[0]);
         @(posedge clock);
         br_valid <= 1'b1;
         br_reg_target <= i[2];
         branch_options_field <= {i[2:0], 1'b1, i[0]};
         br_disp <= i[1] ? 14'h3ffc : {1'b0, i[0], 12'h0};
         @(posedge clock);
         br_valid <= 1'b0;
         @(negedge clock);
         chk_bit("pred_valid_q", 1'b1, pred_valid_q);
         chk_bit("pred_taken_q", exp, pred_taken_q);
      end
   endtask

   task automatic flag_cases();
      for (int s = 0; s < 32; s++) begin
         @(posedge clock);
         flag_valid <= 1'b1;
         condition_flag_select <= s[4:0];
         @(posedge clock);
         flag_valid <= 1'b0;
         @(negedge clock);
         chk_bit("flag_value_q", condition_register[31 - s], flag_value_q);
         chk_vec("flag_field_q", 32'(s / 4), 32'(flag_field_q));
         chk_vec("flag_pos_q", 32'(s % 4), 32'(flag_pos_q));
      end
   endtask

   task automatic spr_op(logic wr, int num, logic [31:0] d, logic hit);
      @(posedge clock);
      spr_valid <= 1'b1;
      spr_write <= wr;
      spr_num <= num[9:0];
      spr_wdata <= d;
      @(posedge clock);
      spr_valid <= 1'b0;
      @(negedge clock);
      chk_bit("spr_hit_q", hit, spr_hit_q);
      chk_bit("spr_bad_q", !hit, spr_bad_q);
      if (!wr) chk_vec("spr_rdata_q", d, spr_rdata_q);
   endtask

   // Unknown numbers must leave both storage and the last read data alone
   task automatic spr_cases();
      foreach (spr_list[i]) spr_op(1'b0, spr_list[i], 32'h0, 1'b1);
      foreach (spr_list[i]) spr_op(1'b1, spr_list[i], 32'hc0de_0000 + spr_list[i], 1'b1);
      foreach (bad_list[i]) spr_op(1'b1, bad_list[i], 32'hffff_ffff, 1'b0);
      foreach (spr_list[i]) spr_op(1'b0, spr_list[i], 32'hc0de_0000 + spr_list[i], 1'b1);
      foreach (bad_list[i]) spr_op(1'b0, bad_list[i], 32'hc0de_0113, 1'b0);
   endtask

   // A read right behind a write to the same number sees the new word
   task automatic spr_b2b();
      @(posedge clock);
      spr_valid <= 1'b1;
      spr_write <= 1'b1;
      spr_num <= 10'h008;
      spr_wdata <= 32'h5a5a_0f0f;
      @(posedge clock);
      spr_write <= 1'b0;
      @(posedge clock);
      spr_valid <= 1'b0;
      @(negedge clock);
      chk_bit("spr_hit_q b2b", 1'b1, spr_hit_q);
      chk_vec("spr_rdata_q b2b", 32'h5a5a_0f0f, spr_rdata_q);
   endtask

   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      sys_rst = 1'b1;
      slow = 1'b0;
      trap_valid = 1'b0;
      trap_imm_form = 1'b0;
      trap_condition_mask = 5'h00;
      first_source_gpr = 32'h0;
      second_source_gpr = 32'h0;
      signed_immediate = 16'h0;
      br_valid = 1'b0;
      br_reg_target = 1'b0;
      branch_options_field = 5'h00;
      br_disp = 14'h0;
      flag_valid = 1'b0;
      condition_flag_select = 5'h00;
      condition_register = 32'h8c35_e16a;
      spr_valid = 1'b0;
      spr_write = 1'b0;
      spr_num = 10'h0;
      spr_wdata = 32'h0;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      run_trap(1'b0, 5'h1f, 32'hffff_ffff, 32'h1);
      run_trap(1'b1, 5'h08, 32'h5, 32'hfffe);
      run_trap(1'b1, 5'h02, 32'h5, 32'hfffe);
      run_trap(1'b1, 5'h10, 32'h5, 32'hfffe);
      run_trap(1'b0, 5'h04, 32'h7, 32'h7);
      run_trap(1'b0, 5'h1b, 32'h7, 32'h7);
      run_trap(1'b0, 5'h10, 32'h8000_0000, 32'h3);
      run_trap(1'b0, 5'h01, 32'h8000_0000, 32'h3);
      run_trap(1'b0, 5'h00, 32'h1, 32'h2);
      trap_refused();
      branch_cases();
      flag_cases();
      spr_cases();
      spr_b2b();
      end_sim();
   end

   initial begin
      repeat (2000) @(posedge clock);
      err_total++;
      end_sim();
   end
endmodule // tb
